// ==== regbank_pkg.sv ====
package regbank_pkg;

  localparam logic [6:0] ADDR_ID = 7'h00;
  localparam logic [6:0] ADDR_PIN_CTRL = 7'h01;
  localparam logic [6:0] ADDR_REF_FAIL_EV = 7'h02;
  localparam logic [6:0] ADDR_LOOP_EV = 7'h03;
  localparam logic [6:0] ADDR_MON_FAIL_LO = 7'h05;
  localparam logic [6:0] ADDR_MON_FAIL_HI = 7'h06;
  localparam logic [6:0] ADDR_REF_FAIL_MASK = 7'h09;
  localparam logic [6:0] ADDR_LOOP_EV_MASK = 7'h0A;
  localparam logic [6:0] ADDR_MON_MASK_LO = 7'h0C;
  localparam logic [6:0] ADDR_MON_MASK_HI = 7'h0D;
  localparam logic [6:0] ADDR_DET_REF_LO = 7'h10;
  localparam logic [6:0] ADDR_DET_REF_HI = 7'h11;
  localparam logic [6:0] ADDR_DET_SYNC_LO = 7'h14;
  localparam logic [6:0] ADDR_DET_SYNC_HI = 7'h15;
  localparam logic [6:0] ADDR_RANGE_LO = 7'h16;
  localparam logic [6:0] ADDR_RANGE_HI = 7'h17;
  localparam logic [6:0] ADDR_SOAK_MASK = 7'h1A;
  localparam logic [6:0] ADDR_SOAK_TIMES = 7'h1C;
  localparam logic [6:0] ADDR_FILTER_CTRL = 7'h1D;
  localparam logic [6:0] ADDR_HOLD_CTRL = 7'h1E;
  localparam logic [6:0] ADDR_OP_MODE = 7'h1F;
  localparam logic [6:0] ADDR_INPUT_SEL = 7'h20;
  localparam logic [6:0] ADDR_SW_FAIL_MASK = 7'h21;
  localparam logic [6:0] ADDR_RESTORE = 7'h22;
  localparam logic [6:0] ADDR_REVERT = 7'h23;
  localparam logic [6:0] ADDR_PRIO_LO = 7'h24;
  localparam logic [6:0] ADDR_PRIO_HI = 7'h25;
  localparam logic [6:0] ADDR_LOCK_STAT = 7'h28;
  localparam logic [6:0] ADDR_CAPTURE = 7'h29;
  localparam logic [6:0] ADDR_FP_LO = 7'h40;
  localparam logic [6:0] ADDR_FP_MID = 7'h41;
  localparam logic [6:0] ADDR_FP_TOP = 7'h42;

  localparam int FP_WIDTH = 22;
  localparam int FP_TOP_BITS = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [FP_WIDTH-1:0] RESET_FP = 22'h000000;

  // Number of control address table entries; the bank holds only the first NUM_RW, the last two are ADDR_ID fillers
  localparam int NUM_CTRL = 21;
  localparam logic [6:0] CTRL_ADDRS [NUM_CTRL] = '{
    ADDR_PIN_CTRL, ADDR_REF_FAIL_MASK, ADDR_LOOP_EV_MASK, ADDR_MON_MASK_LO,
    ADDR_MON_MASK_HI, ADDR_RANGE_LO, ADDR_RANGE_HI, ADDR_SOAK_MASK,
    ADDR_SOAK_TIMES, ADDR_FILTER_CTRL, ADDR_HOLD_CTRL, ADDR_OP_MODE,
    ADDR_INPUT_SEL, ADDR_SW_FAIL_MASK, ADDR_RESTORE, ADDR_REVERT,
    ADDR_PRIO_LO, ADDR_PRIO_HI, ADDR_CAPTURE, ADDR_ID, ADDR_ID};
  localparam int NUM_RW = 19;

  // Host access request from the serial port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  // Live status fed in by the monitors and the loop
  typedef struct packed {
    logic [7:0] ref_fail;
    logic [7:0] loop_ev;
    logic [7:0] mon_lo;
    logic [7:0] mon_hi;
    logic [7:0] det_ref_lo;
    logic [7:0] det_ref_hi;
    logic [7:0] det_sync_lo;
    logic [7:0] det_sync_hi;
    logic [7:0] active_sel;
    logic [7:0] lock_stat;
  } live_stat_s;

endpackage

// ==== multibyte_register_bank.sv ====
`timescale 1ns/1ps
module multibyte_register_bank
  import regbank_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A // Arbitrary identity value
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire host_req_s req,
  input wire live_stat_s stat,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic int_n_q,
  output logic [7:0] ctrl_q [NUM_RW],
  output logic [FP_WIDTH-1:0] frame_offset_q
);

  logic [7:0] loop_ev_q;
  logic [7:0] mon_lo_q;
  logic [7:0] mon_hi_q;
  logic [7:0] fp_lo_sh_q;
  logic [7:0] fp_mid_sh_q;
  logic [15:0] fp_snap_q;
  logic [7:0] rd_d;
  logic [7:0] ctrl_mask_lo;
  logic [7:0] ctrl_mask_loop;
  logic [7:0] ctrl_mask_ml;
  logic [7:0] ctrl_mask_mh;
  logic [7:0] ctrl_mask_rf;

  wire logic rd_loop = req.rd && (req.addr == ADDR_LOOP_EV);
  wire logic rd_mon_lo = req.rd && (req.addr == ADDR_MON_FAIL_LO);
  wire logic rd_mon_hi = req.rd && (req.addr == ADDR_MON_FAIL_HI);

  // Read-write control bytes, one per each of the first NUM_RW table entries; a read of ADDR_INPUT_SEL returns stat.active_sel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RW; gi++) begin : g_ctrl
      always_ff @(posedge core_clk) begin
        if (rst) begin
          ctrl_q[gi] <= RESET_BYTE;
        end else if (req.wr && req.addr == CTRL_ADDRS[gi]) begin
          ctrl_q[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  assign ctrl_mask_rf = ctrl_q[1];
  assign ctrl_mask_loop = ctrl_q[2];
  assign ctrl_mask_ml = ctrl_q[3];
  assign ctrl_mask_mh = ctrl_q[4];
  assign ctrl_mask_lo = ctrl_q[0];

  // Sticky event bytes; a new event wins over the read clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      loop_ev_q <= RESET_BYTE;
      mon_lo_q <= RESET_BYTE;
      mon_hi_q <= RESET_BYTE;
    end else begin
      loop_ev_q <= (rd_loop ? 8'h00 : loop_ev_q) | stat.loop_ev;
      mon_lo_q <= (rd_mon_lo ? 8'h00 : mon_lo_q) | stat.mon_lo;
      mon_hi_q <= (rd_mon_hi ? 8'h00 : mon_hi_q) | stat.mon_hi;
    end
  end

  // Frame offset shadow bytes and commit on top byte write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fp_lo_sh_q <= RESET_BYTE;
      fp_mid_sh_q <= RESET_BYTE;
      frame_offset_q <= RESET_FP;
    end else if (req.wr) begin
      if (req.addr == ADDR_FP_LO) begin
        fp_lo_sh_q <= req.wdata;
      end else if (req.addr == ADDR_FP_MID) begin
        fp_mid_sh_q <= req.wdata;
      end else if (req.addr == ADDR_FP_TOP) begin
        frame_offset_q <= {req.wdata[FP_TOP_BITS-1:0], fp_mid_sh_q, fp_lo_sh_q};
      end
    end
  end

  // Read snapshot of the upper bytes taken on the low byte read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fp_snap_q <= 16'h0000;
    end else if (req.rd && req.addr == ADDR_FP_LO) begin
      fp_snap_q <= {2'b00, frame_offset_q[FP_WIDTH-1:8]};
    end
  end

  // Read multiplexer
  always_comb begin
    rd_d = 8'h00;
    case (req.addr)
      ADDR_ID: rd_d = CHIP_ID;
      ADDR_REF_FAIL_EV: rd_d = stat.ref_fail;
      ADDR_LOOP_EV: rd_d = loop_ev_q;
      ADDR_MON_FAIL_LO: rd_d = mon_lo_q;
      ADDR_MON_FAIL_HI: rd_d = mon_hi_q;
      ADDR_DET_REF_LO: rd_d = stat.det_ref_lo;
      ADDR_DET_REF_HI: rd_d = stat.det_ref_hi;
      ADDR_DET_SYNC_LO: rd_d = stat.det_sync_lo;
      ADDR_DET_SYNC_HI: rd_d = stat.det_sync_hi;
      ADDR_INPUT_SEL: rd_d = stat.active_sel;
      ADDR_LOCK_STAT: rd_d = stat.lock_stat;
      ADDR_FP_LO: rd_d = frame_offset_q[7:0];
      ADDR_FP_MID: rd_d = fp_snap_q[7:0];
      ADDR_FP_TOP: rd_d = {2'b00, fp_snap_q[13:8]};
      default: begin
        rd_d = 8'h00;
        for (int i = 0; i < NUM_RW; i++) begin
          if (req.addr == CTRL_ADDRS[i] && req.addr != ADDR_INPUT_SEL) begin
            rd_d = ctrl_q[i];
          end
        end
      end
    endcase
  end

  // Registered read answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= RESET_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= req.rd ? rd_d : RESET_BYTE;
      rvalid_q <= req.rd;
    end
  end

  // Interrupt: low while any unmasked event is recorded or an unmasked live reference failure stands
  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~(|(stat.ref_fail & ~ctrl_mask_rf) | |(loop_ev_q & ~ctrl_mask_loop)
        | |(mon_lo_q & ~ctrl_mask_ml) | |(mon_hi_q & ~ctrl_mask_mh));
    end
  end

  logic unused_ok;
  assign unused_ok = ^ctrl_mask_lo;

  chk_sticky_hold: assert property (@(posedge core_clk) disable iff (rst)
    $past(stat.loop_ev[0]) |-> loop_ev_q[0])
    else $error("loop event bit lost");
  chk_read_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_loop && stat.loop_ev == 8'h00 |=> loop_ev_q == 8'h00)
    else $error("sticky byte not cleared by read");
  chk_commit_top: assert property (@(posedge core_clk) disable iff (rst)
    !(req.wr && req.addr == ADDR_FP_TOP) |=> $stable(frame_offset_q))
    else $error("offset changed without top write");
  chk_commit_val: assert property (@(posedge core_clk) disable iff (rst)
    req.wr && req.addr == ADDR_FP_TOP |=> frame_offset_q[7:0] == $past(fp_lo_sh_q))
    else $error("offset low byte wrong");
  chk_snap_stable: assert property (@(posedge core_clk) disable iff (rst)
    !(req.rd && req.addr == ADDR_FP_LO) |=> $stable(fp_snap_q))
    else $error("snapshot moved");
  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == 7'h04 |=> rvalid_q && rdata_q == 8'h00)
    else $error("reserved read nonzero");
  chk_id_read: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == ADDR_ID |=> rdata_q == CHIP_ID)
    else $error("identity read wrong");
  chk_int_idle: assert property (@(posedge core_clk) disable iff (rst)
    loop_ev_q == 8'h00 && mon_lo_q == 8'h00 && mon_hi_q == 8'h00
    && stat.ref_fail == 8'h00 |=> int_n_q)
    else $error("interrupt without event");

  // Host access patterns on the wide value and the loop event byte
  sequence s_low_write;
    req.wr && req.addr == ADDR_FP_LO;
  endsequence

  sequence s_mid_write;
    req.wr && req.addr == ADDR_FP_MID;
  endsequence

  sequence s_top_write;
    req.wr && req.addr == ADDR_FP_TOP;
  endsequence

  sequence s_low_read;
    req.rd && req.addr == ADDR_FP_LO;
  endsequence

  sequence s_mid_read;
    req.rd && req.addr == ADDR_FP_MID;
  endsequence

  sequence s_top_read;
    req.rd && req.addr == ADDR_FP_TOP;
  endsequence

  sequence s_loop_read;
    req.rd && req.addr == ADDR_LOOP_EV;
  endsequence

  // Wide value shadow, commit and snapshot
  chk_commit_mid: assert property (@(posedge core_clk) disable iff (rst)
    s_top_write
    |=> frame_offset_q[15:8] == $past(fp_mid_sh_q))
    else $error("offset middle byte wrong");

  chk_commit_bits: assert property (@(posedge core_clk) disable iff (rst)
    s_top_write
    |=> frame_offset_q[21:16] == $past(req.wdata[5:0]))
    else $error("offset top bits wrong");

  chk_low_shadow: assert property (@(posedge core_clk) disable iff (rst)
    s_low_write
    |=> fp_lo_sh_q == $past(req.wdata))
    else $error("low shadow byte wrong");

  chk_mid_shadow: assert property (@(posedge core_clk) disable iff (rst)
    s_mid_write
    |=> fp_mid_sh_q == $past(req.wdata))
    else $error("middle shadow byte wrong");

  chk_snap_take: assert property (@(posedge core_clk) disable iff (rst)
    s_low_read
    |=> fp_snap_q[13:0] == $past(frame_offset_q[21:8]))
    else $error("snapshot not taken");

  chk_low_answer: assert property (@(posedge core_clk) disable iff (rst)
    s_low_read
    |=> rdata_q == $past(frame_offset_q[7:0]))
    else $error("offset low read wrong");

  chk_mid_answer: assert property (@(posedge core_clk) disable iff (rst)
    s_mid_read
    |=> rdata_q == $past(fp_snap_q[7:0]))
    else $error("offset middle read wrong");

  chk_top_answer: assert property (@(posedge core_clk) disable iff (rst)
    s_top_read
    |=> rdata_q == {2'b00, $past(fp_snap_q[13:8])})
    else $error("offset top read wrong");

  // Read answer timing
  chk_read_pulse: assert property (@(posedge core_clk) disable iff (rst)
    req.rd
    |=> rvalid_q)
    else $error("read not answered");

  chk_idle_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !req.rd
    |=> !rvalid_q && rdata_q == 8'h00)
    else $error("answer without read");

  chk_reserved_high: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == 7'h43
    |=> rdata_q == 8'h00)
    else $error("reserved high read nonzero");

  // Sticky event bytes
  chk_loop_set: assert property (@(posedge core_clk) disable iff (rst)
    stat.loop_ev != 8'h00
    |=> (loop_ev_q & $past(stat.loop_ev)) == $past(stat.loop_ev))
    else $error("loop event not recorded");

  chk_mon_lo_set: assert property (@(posedge core_clk) disable iff (rst)
    stat.mon_lo != 8'h00
    |=> (mon_lo_q & $past(stat.mon_lo)) == $past(stat.mon_lo))
    else $error("low failure not recorded");

  chk_mon_hi_set: assert property (@(posedge core_clk) disable iff (rst)
    stat.mon_hi != 8'h00
    |=> (mon_hi_q & $past(stat.mon_hi)) == $past(stat.mon_hi))
    else $error("high failure not recorded");

  chk_mon_lo_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_mon_lo && stat.mon_lo == 8'h00
    |=> mon_lo_q == 8'h00)
    else $error("low failures not cleared");

  chk_mon_hi_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_mon_hi && stat.mon_hi == 8'h00
    |=> mon_hi_q == 8'h00)
    else $error("high failures not cleared");

  chk_loop_hold: assert property (@(posedge core_clk) disable iff (rst)
    !rd_loop
    |=> (loop_ev_q & $past(loop_ev_q)) == $past(loop_ev_q))
    else $error("loop event dropped unread");

  chk_loop_answer: assert property (@(posedge core_clk) disable iff (rst)
    s_loop_read
    |=> rdata_q == $past(loop_ev_q))
    else $error("loop event read wrong");

  // Live status reads
  chk_ref_fail_read: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == ADDR_REF_FAIL_EV
    |=> rdata_q == $past(stat.ref_fail))
    else $error("reference failure read wrong");

  chk_lock_read: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == ADDR_LOCK_STAT
    |=> rdata_q == $past(stat.lock_stat))
    else $error("lock status read wrong");

  chk_sel_read: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == ADDR_INPUT_SEL
    |=> rdata_q == $past(stat.active_sel))
    else $error("active selection read wrong");

  chk_det_ref_read: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == ADDR_DET_REF_LO
    |=> rdata_q == $past(stat.det_ref_lo))
    else $error("detected input read wrong");

  chk_det_sync_read: assert property (@(posedge core_clk) disable iff (rst)
    req.rd && req.addr == ADDR_DET_SYNC_LO
    |=> rdata_q == $past(stat.det_sync_lo))
    else $error("detected frame input read wrong");

  // Interrupt gating by the masks
  chk_int_fire: assert property (@(posedge core_clk) disable iff (rst)
    (stat.ref_fail & ~ctrl_mask_rf) != 8'h00
    |=> !int_n_q)
    else $error("interrupt missed on failure");

  chk_int_loop: assert property (@(posedge core_clk) disable iff (rst)
    (loop_ev_q & ~ctrl_mask_loop) != 8'h00
    |=> !int_n_q)
    else $error("interrupt missed on loop event");

  chk_int_masked: assert property (@(posedge core_clk) disable iff (rst)
    ((mon_lo_q & ~ctrl_mask_ml) | (mon_hi_q & ~ctrl_mask_mh)) == 8'h00
    && (loop_ev_q & ~ctrl_mask_loop) == 8'h00 && (stat.ref_fail & ~ctrl_mask_rf) == 8'h00
    |=> int_n_q)
    else $error("masked event raised interrupt");

  // Control byte writes
  chk_pin_write: assert property (@(posedge core_clk) disable iff (rst)
    req.wr && req.addr == ADDR_PIN_CTRL
    |=> ctrl_q[0] == $past(req.wdata))
    else $error("pin control write lost");

  chk_pin_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(req.wr && req.addr == ADDR_PIN_CTRL)
    |=> $stable(ctrl_q[0]))
    else $error("pin control changed unwritten");

  chk_soak_write: assert property (@(posedge core_clk) disable iff (rst)
    req.wr && req.addr == ADDR_SOAK_MASK
    |=> ctrl_q[7] == $past(req.wdata))
    else $error("soak mask write lost");

  chk_mask_write: assert property (@(posedge core_clk) disable iff (rst)
    req.wr && req.addr == ADDR_LOOP_EV_MASK
    |=> ctrl_q[2] == $past(req.wdata))
    else $error("loop mask write lost");

endmodule

// ==== host_port_model.sv ====
`timescale 1ns/1ps
// Host side of the byte port, one request per call
module host_port_model
  import regbank_pkg::*;
(
  input wire logic core_clk,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q,
  output host_req_s req
);
  initial req = '0;
  // Strobe for one cycle, then drop it and scramble the idle fields
  task automatic release_req(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Byte write, launched at the falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    release_req(a, d);
  endtask
  // Byte read, answer taken while its valid pulse stands
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge core_clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    release_req(a, 8'h00);
    d = (rvalid_q === 1'b1) ? rdata_q : 8'hXX;
  endtask
endmodule

// ==== multibyte_register_bank_test.sv ====
`timescale 1ns/1ps
module multibyte_register_bank_test
  import regbank_pkg::*;
;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary identity value
  logic core_clk;
  logic rst;
  host_req_s req;
  live_stat_s stat;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic int_n_q;
  logic [7:0] ctrl_q [NUM_RW];
  logic [FP_WIDTH-1:0] frame_offset_q;
  int failures;
  int cmp_count;
  int i;

  multibyte_register_bank #(.CHIP_ID(ID)) i_multibyte_register_bank (
    .core_clk(core_clk), .rst(rst), .req(req), .stat(stat), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .int_n_q(int_n_q), .ctrl_q(ctrl_q),
    .frame_offset_q(frame_offset_q));
  host_port_model i_host_port_model (
    .core_clk(core_clk), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .req(req));

  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // Read one byte and compare it
  task automatic rc(input logic [6:0] a, input logic [7:0] e, input string m);
    logic [7:0] d;
    i_host_port_model.rd(a, d);
    chk({24'h0, d}, {24'h0, e}, m);
  endtask

  // Pulse one event input for a single cycle
  task automatic pulse(input int sel, input logic [7:0] v);
    @(negedge core_clk);
    if (sel == 0) stat.loop_ev = v;
    else stat.mon_lo = v;
    @(negedge core_clk);
    stat.loop_ev = 8'h00;
    stat.mon_lo = 8'h00;
    @(negedge core_clk);
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog far beyond the expected run of under one microsecond
  initial begin
    #50000;
    failures++;
    complete_run;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    stat = '0;
    stat.det_ref_lo = 8'h21;
    stat.active_sel = 8'h5C;
    failures = 0;
    cmp_count = 0;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    chk(int_n_q, 1, "int idle");
    rc(ADDR_ID, ID, "identity");
    i_host_port_model.wr(ADDR_ID, 8'hFF);
    rc(ADDR_ID, ID, "identity kept");
    i_host_port_model.wr(7'h04, 8'hFF);
    rc(7'h04, 8'h00, "reserved");
    i_host_port_model.wr(ADDR_DET_REF_LO, 8'hFF);
    rc(ADDR_DET_REF_LO, 8'h21, "status kept");
    $display("test read-only done");
    for (i = 0; i < NUM_RW; i++) i_host_port_model.wr(CTRL_ADDRS[i], 8'(8'h30 + i));
    for (i = 0; i < NUM_RW; i++) begin
      rc(CTRL_ADDRS[i], (i == 12) ? 8'h5C : 8'(8'h30 + i), "ctrl read");
      chk(ctrl_q[i], 8'(8'h30 + i), "ctrl out");
    end
    $display("test control done");
    pulse(0, 8'h05);
    chk(int_n_q, 0, "int set");
    rc(ADDR_LOOP_EV, 8'h05, "sticky");
    @(negedge core_clk);
    chk(int_n_q, 1, "int cleared");
    rc(ADDR_LOOP_EV, 8'h00, "cleared");
    pulse(1, 8'h02);
    chk(int_n_q, 1, "masked");
    rc(ADDR_MON_FAIL_LO, 8'h02, "mon sticky");
    $display("test events done");
    i_host_port_model.wr(ADDR_FP_LO, 8'hAB);
    i_host_port_model.wr(ADDR_FP_MID, 8'hCD);
    chk(frame_offset_q, 0, "held");
    i_host_port_model.wr(ADDR_FP_TOP, 8'hFF);
    chk(frame_offset_q, 22'h3FCDAB, "commit");
    rc(ADDR_FP_LO, 8'hAB, "low");
    i_host_port_model.wr(ADDR_FP_LO, 8'h11);
    i_host_port_model.wr(ADDR_FP_MID, 8'h22);
    i_host_port_model.wr(ADDR_FP_TOP, 8'h01);
    chk(frame_offset_q, 22'h012211, "recommit");
    rc(ADDR_FP_MID, 8'hCD, "snap mid");
    rc(ADDR_FP_TOP, 8'h3F, "snap top");
    $display("test wide value done");
    complete_run;
  end
endmodule
